// file: sac_pkg.sv
`default_nettype none
package sac_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_GPIO0_LIMITS  = 8'h19;
	localparam logic [7:0] OFS_GPIO1_LIMITS  = 8'h1A;
	localparam logic [7:0] OFS_TEMP_LIMITS   = 8'h1B;
	localparam logic [7:0] OFS_CSI_ALARM_EN  = 8'h1C;
	localparam logic [7:0] OFS_LIMIT_ALARM_EN = 8'h1D;
	localparam logic [7:0] OFS_BC_ALARM_EN   = 8'h1E;
	localparam logic [7:0] OFS_LANE_SWAP     = 8'h20;
	localparam logic [7:0] OFS_LP_SWAP       = 8'h21;
	localparam logic [7:0] OFS_HS_RX_DEBUG   = 8'h22;
	localparam logic [7:0] OFS_LP_RX_DEBUG   = 8'h23;
	localparam logic [7:0] OFS_TERM_DEBUG    = 8'h24;
	localparam logic [7:0] OFS_HDR_CTRL      = 8'h31;
	localparam logic [7:0] OFS_SENSE_SELECT  = 8'h38;
	localparam logic [7:0] OFS_CSI_STATUS    = 8'h39;
	localparam logic [7:0] OFS_LIMIT_STATUS  = 8'h3A;
	localparam logic [7:0] OFS_BC_STATUS     = 8'h3B;
	localparam logic [7:0] OFS_CSI_MASK      = 8'h3C;
	localparam logic [7:0] OFS_LIMIT_MASK    = 8'h3D;
	localparam logic [7:0] OFS_BC_MASK       = 8'h3E;
	localparam logic [7:0] OFS_LIVE_STATE    = 8'h3F;
	localparam logic [7:0] OFS_HDR_ID        = 8'h40;
	localparam logic [7:0] OFS_HDR_COUNT_LO  = 8'h41;
	localparam logic [7:0] OFS_HDR_COUNT_HI  = 8'h42;
	// ==========================================================
	// field positions
	localparam int UPPER_LSB   = 4;
	localparam int LOWER_LSB   = 0;
	localparam int LIMIT_W     = 3;
	localparam int CLK_SWAP_BIT = 4;
	localparam int HDR_SEL_LSB = 6;
	localparam int HDR_FIXED_BIT = 5;
	localparam int HDR_PERVC_BIT = 4;
	localparam int SETTLE_LSB  = 0;
	localparam int VC_LSB      = 6;
	localparam int TEMP_EN_BIT = 2;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_LIMITS   = 8'h62;
	localparam logic [7:0] RST_CSI_EN   = 8'h3F;
	localparam logic [7:0] RST_LIMIT_EN = 8'h00;
	localparam logic [7:0] RST_BC_EN    = 8'h00;
	localparam logic [7:0] RST_HDR_CTRL = 8'h20;
	localparam logic [7:0] RST_SENSE_SEL = 8'h04;
	// ==========================================================
	// timing
	localparam int CLK_MHZ        = 125;
	localparam int SETTLE_STEP_US = 100;
	localparam int SETTLE_STEP_CYC = SETTLE_STEP_US * CLK_MHZ;
	localparam int SETTLE_CNT_W   = 20;
	// gpio sense selection codes
	typedef enum logic [1:0] {
		SAC_SENSE_NONE, SAC_SENSE_GPIO0, SAC_SENSE_GPIO1, SAC_SENSE_BOTH
	} sac_sense_t;
endpackage : sac_pkg
`default_nettype wire

// file: sac_alarm_config.sv
`default_nettype none
module sac_alarm_config
	import sac_pkg::*;
#(
	parameter int unsigned SETTLE_STEP = SETTLE_STEP_CYC
) (
	// clock, reset and register port
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [7:0]  regRdData,
	// measurement samples, same clock domain
	input  wire logic        sampleValid,
	input  wire logic [2:0]  gpio0Reading,
	input  wire logic [2:0]  gpio1Reading,
	input  wire logic [2:0]  tempReading,
	// error pulses from link and back channel
	input  wire logic [5:0]  csiErrEvt,
	input  wire logic [1:0]  bcErrEvt,
	// packet headers from the receiver
	input  wire logic        hdrValid,
	input  wire logic [23:0] hdrReceived,
	input  wire logic [23:0] hdrCorrected,
	// lane pins, outside the clock domain
	input  wire logic [4:0]  hsLaneIn,
	input  wire logic [4:0]  lpLaneP,
	input  wire logic [4:0]  lpLaneN,
	// lane results after swap; lp lanes are also held until settle
	output logic      [4:0]  hsLaneOut,
	output logic      [4:0]  lpStateP,
	output logic      [4:0]  lpStateN,
	output logic             settleDone,
	// debug register copies
	output logic      [6:0]  hsRxDebug,
	output logic      [6:0]  lpRxDebug,
	output logic      [7:0]  termDebug,
	// live limit levels and interrupt
	output logic             gpio1HighStatus,
	output logic             gpio1LowStatus,
	output logic             temperatureHighStatus,
	output logic             irq
);
	// ==========================================================
	// parameter check
	// the step counter is SETTLE_CNT_W bits wide, so a longer
	// step cannot be counted and a zero step would wrap to the full counter range
	if (SETTLE_STEP < 1 || SETTLE_STEP >= (1 << SETTLE_CNT_W)) begin : g_bad_step
		$error("SETTLE_STEP out of range");
	end

	localparam logic [SETTLE_CNT_W-1:0] STEP_LAST = SETTLE_CNT_W'(SETTLE_STEP - 1);

	// ==========================================================
	// state
	// every flop of the block lives in this one struct
	// limits: packed upper field 6:4, lower field 2:0
	// enables: one bit per alarm, same layout as status
	// status: sticky, cleared by writing a one
	// masks: route status bits to the interrupt
	// liveFlags: last comparison, follows sense select
	// hdrLast / hdrPerVc: single slot or one per channel
	// hsSync1 / hsSync2: two stage pin synchroniser
	typedef struct packed {
		logic [7:0]       gpio0Limits;
		logic [7:0]       gpio1Limits;
		logic [7:0]       tempLimits;
		logic [5:0]       csiEn;
		logic [5:0]       limitEn;
		logic [1:0]       bcEn;
		logic [4:0]       laneSwap;
		logic [4:0]       lpSwap;
		logic [6:0]       hsDbg;
		logic [6:0]       lpDbg;
		logic [7:0]       termDbg;
		logic [7:0]       hdrCtrl;
		logic [2:0]       senseSel;
		logic [5:0]       csiStat;
		logic [5:0]       limitStat;
		logic [1:0]       bcStat;
		logic [5:0]       csiMask;
		logic [5:0]       limitMask;
		logic [1:0]       bcMask;
		logic [5:0]       liveFlags;
		logic [23:0]      hdrLast;
		logic [3:0][23:0] hdrPerVc;
		logic [14:0]      hsSync1;
		logic [14:0]      hsSync2;
		logic [4:0]       hsOut;
		logic [4:0]       lpP;
		logic [4:0]       lpN;
		logic [SETTLE_CNT_W-1:0] stepCnt;
		logic [2:0]       stepNum;
		logic             settled;
		logic [7:0]       rdData;
	} sac_state_t;

	sac_state_t cur_ff;
	sac_state_t nxt_cur;

	// ==========================================================
	// helpers
	// address match, kept as a function so every
	// decode in the write path reads the same way
	// reserved address bits are not ignored: an
	// alias of a register would hide software bugs
	function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ofs);
		isAddr = (a == ofs);
	endfunction : isAddr

	// over and under test of a reading against packed limits, bit1 over, bit0 under
	function automatic logic [1:0] limitCheck(input logic [2:0] rd, input logic [7:0] lim);
		limitCheck[1] = rd > lim[UPPER_LSB +: LIMIT_W];
		limitCheck[0] = rd < lim[LOWER_LSB +: LIMIT_W];
	endfunction : limitCheck

	logic [1:0] gpio0Cmp;
	logic [1:0] gpio1Cmp;
	logic [1:0] tempCmp;
	logic       gpio0On;
	logic       gpio1On;
	logic       tempOn;
	logic [5:0] limitRaw;
	logic [5:0] limitEvt;
	logic [5:0] csiEvt;
	logic [1:0] bcEvt;
	logic [1:0] hdrVc;
	logic [23:0] hdrView;
	logic       wr;
	logic [23:0] hdrPick;

	// ==========================================================
	// event detection and enables
	// comparisons are strict: a reading equal to a
	// limit raises nothing, so limit 7 over and
	// limit 0 under can never fire
	// sense select gates the raw flags, the alarm
	// enables gate only the sticky events
	always_comb begin
		gpio0Cmp = limitCheck(gpio0Reading, cur_ff.gpio0Limits);
		gpio1Cmp = limitCheck(gpio1Reading, cur_ff.gpio1Limits);
		tempCmp  = limitCheck(tempReading, cur_ff.tempLimits);
		gpio0On  = cur_ff.senseSel[0];
		gpio1On  = cur_ff.senseSel[1];
		tempOn   = cur_ff.senseSel[TEMP_EN_BIT];
		limitRaw = {tempCmp & {2{tempOn}}, gpio1Cmp & {2{gpio1On}}, gpio0Cmp & {2{gpio0On}}};
		limitEvt = limitRaw & cur_ff.limitEn & {6{sampleValid}};
		csiEvt   = csiErrEvt & cur_ff.csiEn;
		bcEvt    = bcErrEvt & cur_ff.bcEn;
		hdrVc    = hdrReceived[VC_LSB +: 2];
		hdrView  = cur_ff.hdrCtrl[HDR_FIXED_BIT] ? hdrCorrected : hdrReceived;
		wr       = regWrStb;
		hdrPick  = hdrSel(cur_ff);
	end

	// ==========================================================
	// next state
	always_comb begin
		nxt_cur = cur_ff;

		// register writes
		// reserved bits are masked here so they read
		// back as zero; status writes only clear bits
		// unmapped addresses fall through and change
		// nothing, and a write lands at its own edge
		// so a read right after sees the new value
		if (wr) begin
			if (isAddr(regAddr, OFS_GPIO0_LIMITS))   nxt_cur.gpio0Limits = regWrData & 8'h77;
			if (isAddr(regAddr, OFS_GPIO1_LIMITS))   nxt_cur.gpio1Limits = regWrData & 8'h77;
			if (isAddr(regAddr, OFS_TEMP_LIMITS))    nxt_cur.tempLimits = regWrData & 8'h77;
			if (isAddr(regAddr, OFS_CSI_ALARM_EN))   nxt_cur.csiEn = regWrData[5:0];
			if (isAddr(regAddr, OFS_LIMIT_ALARM_EN)) nxt_cur.limitEn = regWrData[5:0];
			if (isAddr(regAddr, OFS_BC_ALARM_EN))    nxt_cur.bcEn = regWrData[1:0];
			if (isAddr(regAddr, OFS_LANE_SWAP))      nxt_cur.laneSwap = regWrData[4:0];
			if (isAddr(regAddr, OFS_LP_SWAP))        nxt_cur.lpSwap = regWrData[4:0];
			if (isAddr(regAddr, OFS_HS_RX_DEBUG))    nxt_cur.hsDbg = regWrData[6:0];
			if (isAddr(regAddr, OFS_LP_RX_DEBUG))    nxt_cur.lpDbg = regWrData[6:0];
			if (isAddr(regAddr, OFS_TERM_DEBUG))     nxt_cur.termDbg = regWrData;
			if (isAddr(regAddr, OFS_HDR_CTRL))       nxt_cur.hdrCtrl = regWrData & 8'hF7;
			if (isAddr(regAddr, OFS_SENSE_SELECT))   nxt_cur.senseSel = regWrData[2:0];
			if (isAddr(regAddr, OFS_CSI_MASK))       nxt_cur.csiMask = regWrData[5:0];
			if (isAddr(regAddr, OFS_LIMIT_MASK))     nxt_cur.limitMask = regWrData[5:0];
			if (isAddr(regAddr, OFS_BC_MASK))        nxt_cur.bcMask = regWrData[1:0];
			if (isAddr(regAddr, OFS_CSI_STATUS))     nxt_cur.csiStat = cur_ff.csiStat & ~regWrData[5:0];
			if (isAddr(regAddr, OFS_LIMIT_STATUS))
				nxt_cur.limitStat = cur_ff.limitStat & ~regWrData[5:0];
			if (isAddr(regAddr, OFS_BC_STATUS))      nxt_cur.bcStat = cur_ff.bcStat & ~regWrData[1:0];
		end

		// sticky alarm status, a new event wins over a clear in the same cycle
		// or-ing after the write path means an event
		// in the clearing cycle is never lost
		// limit events only count on a sample strobe
		nxt_cur.csiStat   = nxt_cur.csiStat | csiEvt;
		nxt_cur.limitStat = nxt_cur.limitStat | limitEvt;
		nxt_cur.bcStat    = nxt_cur.bcStat | bcEvt;

		// live limit flags refreshed on each sample
		if (sampleValid) begin
			nxt_cur.liveFlags = limitRaw;
		end

		// header capture
		// the channel comes from the raw header even
		// when the corrected view is stored, so one
		// header with a corrected channel field can land in the wrong slot
		// slots hold their value until overwritten
		if (hdrValid) begin
			if (cur_ff.hdrCtrl[HDR_PERVC_BIT]) begin
				nxt_cur.hdrPerVc[hdrVc] = hdrView;
			end else begin
				nxt_cur.hdrLast = hdrView;
			end
		end

		// pin synchronisers, two stages
		// bits 4:0 high speed, 9:5 lp p, 14:10 lp n
		// only the second stage feeds logic; lanes are
		// synchronised bit by bit, so a multi-bit
		// change may show for one cycle as mixed
		nxt_cur.hsSync1 = {lpLaneN, lpLaneP, hsLaneIn};
		nxt_cur.hsSync2 = cur_ff.hsSync1;

		// high speed inversion per lane
		nxt_cur.hsOut = cur_ff.hsSync2[4:0] ^ cur_ff.laneSwap;

		// low power p/n exchange, held at stop state while settling
		// while settling both lines read high, the
		// stop state, so downstream logic sees no
		// control sequence from a lane still waking
		// after settle each lane swaps p and n alone
		for (int i = 0; i < 5; i++) begin
			if (!cur_ff.settled) begin
				nxt_cur.lpP[i] = 1'b1;
				nxt_cur.lpN[i] = 1'b1;
			end else if (cur_ff.lpSwap[i]) begin
				nxt_cur.lpP[i] = cur_ff.hsSync2[10 + i];
				nxt_cur.lpN[i] = cur_ff.hsSync2[5 + i];
			end else begin
				nxt_cur.lpP[i] = cur_ff.hsSync2[5 + i];
				nxt_cur.lpN[i] = cur_ff.hsSync2[10 + i];
			end
		end

		// settle timer after reset, code plus one steps
		// stepCnt counts clocks inside one step,
		// stepNum counts finished steps
		// the code is read live, so a write during
		// settling moves the end point; a code below
		// the steps already done ends at the next step
		// once settled the timer stops until reset
		if (!cur_ff.settled) begin
			if (cur_ff.stepCnt == STEP_LAST) begin
				nxt_cur.stepCnt = '0;
				if (cur_ff.stepNum >= cur_ff.hdrCtrl[SETTLE_LSB +: 3]) begin
					nxt_cur.settled = 1'b1;
				end else begin
					nxt_cur.stepNum = cur_ff.stepNum + 3'h1;
				end
			end else begin
				nxt_cur.stepCnt = cur_ff.stepCnt + SETTLE_CNT_W'(1);
			end
		end

		// read data, valid the cycle after the strobe
		// the register returns to zero after one
		// cycle so stale data never reads as valid
		// header bytes: id, word count low, high
		nxt_cur.rdData = 8'h00;
		if (regRdStb) begin
			case (regAddr)
				OFS_GPIO0_LIMITS:   nxt_cur.rdData = cur_ff.gpio0Limits;
				OFS_GPIO1_LIMITS:   nxt_cur.rdData = cur_ff.gpio1Limits;
				OFS_TEMP_LIMITS:    nxt_cur.rdData = cur_ff.tempLimits;
				OFS_CSI_ALARM_EN:   nxt_cur.rdData = {2'h0, cur_ff.csiEn};
				OFS_LIMIT_ALARM_EN: nxt_cur.rdData = {2'h0, cur_ff.limitEn};
				OFS_BC_ALARM_EN:    nxt_cur.rdData = {6'h00, cur_ff.bcEn};
				OFS_LANE_SWAP:      nxt_cur.rdData = {3'h0, cur_ff.laneSwap};
				OFS_LP_SWAP:        nxt_cur.rdData = {3'h0, cur_ff.lpSwap};
				OFS_HS_RX_DEBUG:    nxt_cur.rdData = {1'h0, cur_ff.hsDbg};
				OFS_LP_RX_DEBUG:    nxt_cur.rdData = {1'h0, cur_ff.lpDbg};
				OFS_TERM_DEBUG:     nxt_cur.rdData = cur_ff.termDbg;
				OFS_HDR_CTRL:       nxt_cur.rdData = cur_ff.hdrCtrl;
				OFS_SENSE_SELECT:   nxt_cur.rdData = {5'h00, cur_ff.senseSel};
				OFS_CSI_STATUS:     nxt_cur.rdData = {2'h0, cur_ff.csiStat};
				OFS_LIMIT_STATUS:   nxt_cur.rdData = {2'h0, cur_ff.limitStat};
				OFS_BC_STATUS:      nxt_cur.rdData = {6'h00, cur_ff.bcStat};
				OFS_CSI_MASK:       nxt_cur.rdData = {2'h0, cur_ff.csiMask};
				OFS_LIMIT_MASK:     nxt_cur.rdData = {2'h0, cur_ff.limitMask};
				OFS_BC_MASK:        nxt_cur.rdData = {6'h00, cur_ff.bcMask};
				OFS_LIVE_STATE:     nxt_cur.rdData = {cur_ff.settled, 1'b0, cur_ff.liveFlags};
				OFS_HDR_ID:         nxt_cur.rdData = hdrPick[7:0];
				OFS_HDR_COUNT_LO:   nxt_cur.rdData = hdrPick[15:8];
				OFS_HDR_COUNT_HI:   nxt_cur.rdData = hdrPick[23:16];
				default:            nxt_cur.rdData = 8'h00;
			endcase
		end
	end

	// selected header: channel select only applies with per-channel capture
	function automatic logic [23:0] hdrSel(input sac_state_t s);
		if (s.hdrCtrl[HDR_PERVC_BIT])
			hdrSel = s.hdrPerVc[s.hdrCtrl[HDR_SEL_LSB +: 2]];
		else
			hdrSel = s.hdrLast;
	endfunction : hdrSel

	// ==========================================================
	// state register
	// reset clears everything, then loads the
	// documented non-zero defaults; lp lines
	// start in stop state so no false control
	// sequence appears at reset release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_ff             <= '0;
			cur_ff.gpio0Limits <= RST_LIMITS;
			cur_ff.gpio1Limits <= RST_LIMITS;
			cur_ff.tempLimits  <= RST_LIMITS;
			cur_ff.csiEn       <= RST_CSI_EN[5:0];
			cur_ff.limitEn     <= RST_LIMIT_EN[5:0];
			cur_ff.bcEn        <= RST_BC_EN[1:0];
			cur_ff.hdrCtrl     <= RST_HDR_CTRL;
			cur_ff.senseSel    <= RST_SENSE_SEL[2:0];
			cur_ff.lpP         <= 5'h1F;
			cur_ff.lpN         <= 5'h1F;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ==========================================================
	// outputs
	// every output except irq comes straight from a flop
	// debug copies are for bench work only and
	// should stay zero in normal operation
	// the interrupt is a level: it drops only
	// when status is cleared or masked off
	assign regRdData             = cur_ff.rdData;
	assign hsLaneOut             = cur_ff.hsOut;
	assign lpStateP              = cur_ff.lpP;
	assign lpStateN              = cur_ff.lpN;
	assign settleDone            = cur_ff.settled;
	assign hsRxDebug             = cur_ff.hsDbg;
	assign lpRxDebug             = cur_ff.lpDbg;
	assign termDebug             = cur_ff.termDbg;
	assign gpio1HighStatus       = cur_ff.liveFlags[3];
	assign gpio1LowStatus        = cur_ff.liveFlags[2];
	assign temperatureHighStatus = cur_ff.liveFlags[5];
	assign irq = |(cur_ff.csiStat & cur_ff.csiMask) | |(cur_ff.limitStat & cur_ff.limitMask)
		| |(cur_ff.bcStat & cur_ff.bcMask);
endmodule : sac_alarm_config
`default_nettype wire

// file: sac_sensor_model.sv
`default_nettype none
module sac_sensor_model
	import sac_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [4:0]  lanePat,
	input  wire logic        sendHdr,
	input  wire logic [1:0]  hdrVc,
	output logic      [4:0]  hsLaneIn,
	output logic      [4:0]  lpLaneP,
	output logic      [4:0]  lpLaneN,
	output logic             hdrValid,
	output logic      [23:0] hdrReceived,
	output logic      [23:0] hdrCorrected
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// lanes: N line is always the complement of P
	assign hsLaneIn = lanePat;
	assign lpLaneP  = lanePat;
	assign lpLaneN  = ~lanePat;
	// header strobe; between strobes the bus toggles so stale values never match
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hdrValid <= 1'b0;
			hdrReceived <= 24'h000000;
			hdrCorrected <= 24'h000000;
		end else begin
			hdrValid <= sendHdr;
			hdrReceived <= sendHdr ? {16'h0100, hdrVc, 6'h2B} : ~hdrReceived;
			hdrCorrected <= sendHdr ? {16'h0100, hdrVc, 6'h2A} : ~hdrReceived;
		end
	end
endmodule : sac_sensor_model
`default_nettype wire

// file: sac_alarm_config_checker.sv
`default_nettype none
module sac_alarm_config_checker
	import sac_pkg::*;
#(
	parameter int unsigned SETTLE_STEP = SETTLE_STEP_CYC
) (
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrStb,
	input wire logic       sampleValid,
	input wire logic [2:0] gpio1Reading,
	input wire logic [2:0] tempReading,
	input wire logic [4:0] hsLaneIn,
	input wire logic [4:0] hsLaneOut,
	input wire logic [4:0] lpStateP,
	input wire logic [4:0] lpStateN,
	input wire logic       settleDone,
	input wire logic       gpio1HighStatus,
	input wire logic       gpio1LowStatus,
	input wire logic       temperatureHighStatus,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// shadow copies of the registers the checks depend on
	logic [7:0]  v1Lim, tLim, sense, hdrCtl;
	logic [4:0]  swap;
	logic [2:0]  maskNz;
	int unsigned cyc, stab, due;
	assign due = (hdrCtl[2:0] + 1) * SETTLE_STEP;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{v1Lim, tLim} <= {RST_LIMITS, RST_LIMITS};
			{sense, hdrCtl} <= {RST_SENSE_SEL, RST_HDR_CTRL};
			{swap, maskNz} <= 8'h00;
			{cyc, stab} <= 64'h0;
		end else begin
			cyc <= cyc + 1;
			stab <= ($stable(hsLaneIn) && !(regWrStb && regAddr == OFS_LANE_SWAP)) ? stab + 1 : 0;
			if (regWrStb) begin
				case (regAddr)
					OFS_GPIO1_LIMITS: v1Lim <= regWrData;
					OFS_TEMP_LIMITS: tLim <= regWrData;
					OFS_LANE_SWAP: swap <= regWrData[4:0];
					OFS_SENSE_SELECT: sense <= regWrData;
					OFS_HDR_CTRL: hdrCtl <= regWrData;
					OFS_CSI_MASK: maskNz[0] <= |regWrData[5:0];
					OFS_LIMIT_MASK: maskNz[1] <= |regWrData[5:0];
					OFS_BC_MASK: maskNz[2] <= |regWrData[1:0];
					default: ;
				endcase
			end
		end
	end
	// ==========
	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_hs_swap; stab >= 4 |-> hsLaneOut == (hsLaneIn ^ swap); endproperty
	a_hs_swap: assert property (p_hs_swap) else $error("lane polarity wrong");
	property p_lp_hold; !settleDone |-> lpStateP == 5'h1F && lpStateN == 5'h1F; endproperty
	a_lp_hold: assert property (p_lp_hold) else $error("lp state before settle");
	property p_settle_time; $rose(settleDone) |-> cyc + 1 >= due && cyc <= due + 2; endproperty
	a_settle_time: assert property (p_settle_time) else $error("settle time wrong");
	property p_settle_hold; settleDone |=> settleDone; endproperty
	a_settle_hold: assert property (p_settle_hold) else $error("settle dropped");
	property p_v1_high;
		sampleValid && sense[1] |=> gpio1HighStatus == ($past(gpio1Reading) > $past(v1Lim[6:4]));
	endproperty
	a_v1_high: assert property (p_v1_high) else $error("gpio1 high wrong");
	property p_v1_low;
		sampleValid && sense[1] |=> gpio1LowStatus == ($past(gpio1Reading) < $past(v1Lim[2:0]));
	endproperty
	a_v1_low: assert property (p_v1_low) else $error("gpio1 low wrong");
	property p_t_high;
		sampleValid && sense[2] |=> temperatureHighStatus == ($past(tempReading) > $past(tLim[6:4]));
	endproperty
	a_t_high: assert property (p_t_high) else $error("temp high wrong");
	property p_irq_quiet; (maskNz == 3'h0) [*2] |-> !irq; endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq with all masked");
	c_settle: cover property ($rose(settleDone));
	c_irq: cover property ($rose(irq));
	c_high: cover property ($rose(gpio1HighStatus));
endmodule : sac_alarm_config_checker
bind sac_alarm_config sac_alarm_config_checker #(.SETTLE_STEP(SETTLE_STEP))
	sac_alarm_config_checker_i (.*);
`default_nettype wire

// file: sac_alarm_config_tb.sv
`default_nettype none
module sac_alarm_config_tb
	import sac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 4;
	// ==========
	// stimulus and observed signals
	logic        ref_clk = 1'b0, rst_b = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
	logic        sampleValid = 1'b0, sendHdr = 1'b0;
	logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData;
	logic [2:0]  gpio0Reading = 3'h0, gpio1Reading = 3'h0, tempReading = 3'h0;
	logic [5:0]  csiErrEvt = 6'h00;
	logic [1:0]  bcErrEvt = 2'h0, hdrVc = 2'h0;
	logic [4:0]  lanePat = 5'h00, hsLaneIn, lpLaneP, lpLaneN, hsLaneOut, lpStateP, lpStateN;
	logic [23:0] hdrReceived, hdrCorrected;
	logic [6:0]  hsRxDebug, lpRxDebug;
	logic [7:0]  termDebug;
	logic        hdrValid, settleDone, gpio1HighStatus, gpio1LowStatus;
	logic        temperatureHighStatus, irq;
	int          n_errors = 0;
	int          n_tests = 0;
	// device, sensor model and clock
	sac_alarm_config #(.SETTLE_STEP(STEP)) sac_alarm_config_i (.*);
	sac_sensor_model sac_sensor_model_i (.*);
	always #4 ref_clk = ~ref_clk;
	// ==========
	// shared tasks
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic results();
		if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		#1 chk(what, {16'h0, regRdData}, {16'h0, exp});
		@(posedge ref_clk);
	endtask : rd
	task automatic sample(input logic [2:0] g, input logic [2:0] t, input logic sel);
		gpio1Reading <= g;
		tempReading <= t;
		sampleValid <= 1'b1;
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		#1 chk("gpio1 high", gpio1HighStatus, sel && g > 3'h5);
		chk("gpio1 low", gpio1LowStatus, sel && g < 3'h2);
		chk("temp high", temperatureHighStatus, t > 3'h6);
		@(posedge ref_clk);
	endtask : sample
	task automatic pulse(input logic [5:0] c, input logic [1:0] b);
		csiErrEvt <= c;
		bcErrEvt <= b;
		@(posedge ref_clk);
		{csiErrEvt, bcErrEvt} <= 8'h00;
		@(posedge ref_clk);
	endtask : pulse
	task automatic hdr(input logic [1:0] vc);
		hdrVc <= vc;
		sendHdr <= 1'b1;
		@(posedge ref_clk);
		sendHdr <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : hdr
	// ==========
	// scenarios
	task automatic t_settle();
		int n;
		rst_b <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		wr(OFS_HDR_CTRL, 8'h27);
		chk("lp stop", {lpStateP, lpStateN}, 10'h3FF);
		for (n = 2; n < 100 && settleDone !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (n == 100) begin
			n_errors++;
			results();
		end
		chk("settle", n >= 8 * STEP - 1 && n <= 8 * STEP + 2, 1'b1);
		@(posedge ref_clk);
		rd(OFS_HDR_CTRL, 8'h27, "hdr ctrl");
	endtask : t_settle
	task automatic t_regs();
		logic [7:0] a [9] = '{OFS_GPIO1_LIMITS, OFS_TEMP_LIMITS, OFS_CSI_ALARM_EN,
			OFS_LIMIT_ALARM_EN, OFS_BC_ALARM_EN, OFS_LANE_SWAP, OFS_LP_SWAP, OFS_HS_RX_DEBUG, 8'h50};
		logic [7:0] e [9] = '{8'h62, 8'h62, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) rd(a[i], e[i], "reset value");
		wr(8'h50, 8'hAA);
		rd(8'h50, 8'h00, "unmapped");
		wr(OFS_LANE_SWAP, 8'hFF);
		rd(OFS_LANE_SWAP, 8'h1F, "lane swap");
		wr(OFS_HS_RX_DEBUG, 8'hFF);
		rd(OFS_HS_RX_DEBUG, 8'h7F, "hs debug");
		chk("hs debug out", hsRxDebug, 7'h7F);
		wr(OFS_HS_RX_DEBUG, 8'h00);
		wr(OFS_LP_RX_DEBUG, 8'hFF);
		wr(OFS_TERM_DEBUG, 8'hA5);
		chk("lp debug out", lpRxDebug, 7'h7F);
		chk("term debug out", termDebug, 8'hA5);
		wr(OFS_LP_RX_DEBUG, 8'h00);
		wr(OFS_TERM_DEBUG, 8'h00);
		chk("term debug zero", termDebug, 8'h00);
	endtask : t_regs
	task automatic t_lanes();
		wr(OFS_LANE_SWAP, 8'h15);
		wr(OFS_LP_SWAP, 8'h11);
		lanePat <= 5'h0A;
		repeat (5) @(posedge ref_clk);
		chk("hs lanes", hsLaneOut, 5'h1F);
		chk("lp lanes", {lpStateP, lpStateN}, {5'h1B, 5'h04});
	endtask : t_lanes
	task automatic t_limits();
		wr(OFS_SENSE_SELECT, 8'h06);
		wr(OFS_GPIO1_LIMITS, 8'h52);
		wr(OFS_LIMIT_ALARM_EN, 8'h3C);
		wr(OFS_LIMIT_MASK, 8'h08);
		sample(3'h6, 3'h7, 1'b1);
		sample(3'h5, 3'h6, 1'b1);
		sample(3'h2, 3'h2, 1'b1);
		sample(3'h1, 3'h3, 1'b1);
		rd(OFS_LIMIT_STATUS, 8'h2C, "limit status");
		chk("limit irq", irq, 1'b1);
		wr(OFS_LIMIT_STATUS, 8'h2C);
		wr(OFS_SENSE_SELECT, 8'h04);
		sample(3'h7, 3'h0, 1'b0);
		rd(OFS_LIMIT_STATUS, 8'h10, "temp under");
		chk("masked irq", irq, 1'b0);
		wr(OFS_LIMIT_STATUS, 8'h10);
		wr(OFS_SENSE_SELECT, 8'h05);
		wr(OFS_LIMIT_ALARM_EN, 8'h01);
		sample(3'h7, 3'h3, 1'b0);
		rd(OFS_LIMIT_STATUS, 8'h01, "gpio0 under");
	endtask : t_limits
	task automatic t_alarms();
		wr(OFS_CSI_MASK, 8'h3F);
		for (int i = 0; i < 6; i++) begin
			pulse(6'h01 << i, 2'h0);
			chk("csi irq", irq, 1'b1);
			rd(OFS_CSI_STATUS, 8'h01 << i, "csi status");
			wr(OFS_CSI_STATUS, 8'h01 << i);
		end
		chk("irq cleared", irq, 1'b0);
		wr(OFS_CSI_ALARM_EN, 8'h00);
		wr(OFS_BC_ALARM_EN, 8'h02);
		pulse(6'h3F, 2'h3);
		rd(OFS_CSI_STATUS, 8'h00, "csi disabled");
		rd(OFS_BC_STATUS, 8'h02, "bc status");
	endtask : t_alarms
	task automatic t_header();
		wr(OFS_HDR_CTRL, 8'hB7);
		hdr(2'h2);
		rd(OFS_HDR_ID, 8'hAA, "fixed header");
		wr(OFS_HDR_CTRL, 8'h97);
		hdr(2'h2);
		rd(OFS_HDR_ID, 8'hAB, "raw header");
		wr(OFS_HDR_CTRL, 8'h57);
		rd(OFS_HDR_ID, 8'h00, "empty channel");
		wr(OFS_HDR_CTRL, 8'h47);
		hdr(2'h2);
		rd(OFS_HDR_ID, 8'hAB, "select ignored");
	endtask : t_header
	// ==========
	// main sequence and watchdog
	initial begin
		t_settle();
		t_regs();
		t_lanes();
		t_limits();
		t_alarms();
		t_header();
		t_settle();
		results();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		n_errors++;
		results();
	end
endmodule : sac_alarm_config_tb
`default_nettype wire
